// file: design/scd_decoder.sv
// Overview of operation
// - Accept only extended-identifier data frames; ignore standard and remote frames.
// - Identifier bits 28..8 give control mode, bits 7..0 give node ID.
// - Mode codes 0..6: duty, current, brake, velocity, position, origin, pos-vel.
// - Set-points are big-endian: payload byte 0 is bits 31..24.
// - Duty set-point is duty fraction times 100000, applied as voltage ratio.
// - Current-loop value is milliamperes, -60000 to 60000.
// - Brake current is milliamperes, 0 to 60000.
// - Current-loop mode regulates commanded quadrature current, torque follows it.
// - Brake mode applies commanded braking current to hold position.
// - Duty mode drives the motor at the commanded duty, square-wave style.
// - Velocity mode runs the motor at the commanded speed.
// - Position mode moves to target at maximum speed when impedance_select_in is low.
// - Position-velocity mode honours commanded speed and acceleration limits.
// - Impedance position tracking defaults to 12000 electrical rpm and 40000 acceleration.
// - Velocity value is electrical rpm, -100000 to 100000.
// - Position value is degrees times 10000, within plus or minus 360000000.
// - Origin byte 0 sets temporary origin, 1 sets permanent zero.
`timescale 1ns/1ps

module scd_decoder (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [scd_pkg::NODE_W-1:0] node_id_in,
  input wire logic impedance_select_in,
  input wire logic frame_valid_in,
  input wire logic frame_extended_in,
  input wire logic frame_remote_in,
  input wire logic [scd_pkg::ID_W-1:0] frame_id_in,
  input wire logic [scd_pkg::DLC_W-1:0] frame_dlc_in,
  input wire logic [scd_pkg::DATA_W-1:0] frame_data_in,
  output logic frame_ready_out,
  output logic command_strobe_out,
  output logic frame_drop_out,
  output logic mode_valid_out,
  output logic [scd_pkg::CODE_W-1:0] mode_out,
  output logic signed [31:0] duty_out,
  output logic signed [31:0] quadrature_current_out,
  output logic signed [31:0] brake_current_out,
  output logic signed [31:0] velocity_out,
  output logic signed [31:0] position_out,
  output logic signed [31:0] speed_limit_out,
  output logic signed [31:0] accel_limit_out,
  output logic origin_set_out,
  output logic origin_permanent_out
);
  import scd_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic signed [31:0] scd_sat(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Times ten by shifts; inputs are 16-bit so nothing overflows
  function automatic logic signed [31:0] scd_x10(input logic signed [15:0] v);
    logic signed [31:0] w;
    w = 32'(v);
    return (w <<< 3) + (w <<< 1);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  scd_state_type state_q, state_d;
  logic ready_q, ready_d;
  logic [ID_W-1:0] id_q, id_d;
  logic [DLC_W-1:0] dlc_q, dlc_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic ext_q, ext_d;
  logic remote_q, remote_d;
  logic strobe_q, strobe_d;
  logic drop_q, drop_d;
  logic mode_valid_q, mode_valid_d;
  logic [CODE_W-1:0] mode_q, mode_d;
  logic signed [31:0] duty_q, duty_d;
  logic signed [31:0] iq_q, iq_d;
  logic signed [31:0] brake_q, brake_d;
  logic signed [31:0] vel_q, vel_d;
  logic signed [31:0] pos_q, pos_d;
  logic signed [31:0] spd_q, spd_d;
  logic signed [31:0] acc_q, acc_d;
  logic origin_q, origin_d;
  logic perm_q, perm_d;

  logic [MODE_W-1:0] code;
  logic signed [31:0] word;
  logic signed [31:0] accel_units;
  logic frame_ok;
  logic take;

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  assign code = id_q[MODE_MSB:MODE_LSB];
  assign word = data_q[WORD_MSB:WORD_LSB];
  assign accel_units = scd_sat(32'(signed'(data_q[ACCEL_MSB:ACCEL_LSB])),
                               BRAKE_MIN, ACCEL_UNIT_MAX);
  // Foreign node IDs are dropped before any mode is looked at
  assign frame_ok = ext_q && !remote_q
                    && (id_q[NODE_MSB:NODE_LSB] == node_id_in);
  assign take = frame_valid_in && ready_q;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    id_d = id_q;
    dlc_d = dlc_q;
    data_d = data_q;
    ext_d = ext_q;
    remote_d = remote_q;
    strobe_d = 1'b0;
    drop_d = 1'b0;
    origin_d = 1'b0;
    mode_valid_d = mode_valid_q;
    mode_d = mode_q;
    duty_d = duty_q;
    iq_d = iq_q;
    brake_d = brake_q;
    vel_d = vel_q;
    pos_d = pos_q;
    spd_d = spd_q;
    acc_d = acc_q;
    perm_d = perm_q;
    unique case (state_q)
      SCD_IDLE: begin
        if (take) begin
          id_d = frame_id_in;
          dlc_d = frame_dlc_in;
          data_d = frame_data_in;
          ext_d = frame_extended_in;
          remote_d = frame_remote_in;
          ready_d = 1'b0;
          state_d = SCD_DECODE;
        end else begin
          // Also raises ready on the first edge after reset
          ready_d = 1'b1;
        end
      end
      SCD_DECODE: begin
        ready_d = 1'b1;
        state_d = SCD_IDLE;
        drop_d = 1'b1;
        if (frame_ok) begin
          // Short payloads are dropped rather than half-applied
          unique case (code)
            DUTY_COMMAND_CODE: begin
              if (dlc_q >= DLC_WORD) begin
                duty_d = scd_sat(word, DUTY_MIN, DUTY_MAX);
                mode_d = CODE_W'(DUTY_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            CURRENT_COMMAND_CODE: begin
              if (dlc_q >= DLC_WORD) begin
                iq_d = scd_sat(word, CURRENT_MIN, CURRENT_MAX);
                mode_d = CODE_W'(CURRENT_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            BRAKE_COMMAND_CODE: begin
              if (dlc_q >= DLC_WORD) begin
                brake_d = scd_sat(word, BRAKE_MIN, CURRENT_MAX);
                mode_d = CODE_W'(BRAKE_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            VELOCITY_COMMAND_CODE: begin
              if (dlc_q >= DLC_WORD) begin
                vel_d = scd_sat(word, VELOCITY_MIN, VELOCITY_MAX);
                mode_d = CODE_W'(VELOCITY_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            POSITION_COMMAND_CODE: begin
              if (dlc_q >= DLC_WORD) begin
                pos_d = scd_sat(word, POSITION_MIN, POSITION_MAX);
                // Impedance tracking is gentler than a full-speed move
                if (impedance_select_in) begin
                  spd_d = IMPEDANCE_SPEED;
                  acc_d = IMPEDANCE_ACCEL;
                end else begin
                  spd_d = FULL_SPEED;
                  acc_d = FULL_ACCEL;
                end
                mode_d = CODE_W'(POSITION_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            ORIGIN_COMMAND_CODE: begin
              // Origin leaves the running mode untouched
              if (dlc_q >= DLC_ORIGIN) begin
                if (data_q[BYTE0_MSB:BYTE0_LSB] == ORIGIN_TEMPORARY) begin
                  origin_d = 1'b1;
                  perm_d = 1'b0;
                  drop_d = 1'b0;
                end else if (data_q[BYTE0_MSB:BYTE0_LSB] == ORIGIN_PERMANENT) begin
                  origin_d = 1'b1;
                  perm_d = 1'b1;
                  drop_d = 1'b0;
                end
              end
            end
            POSITION_VELOCITY_COMMAND_CODE: begin
              if (dlc_q >= DLC_POS_SPD) begin
                pos_d = scd_sat(word, POSITION_MIN, POSITION_MAX);
                spd_d = scd_x10(data_q[SPEED_MSB:SPEED_LSB]);
                acc_d = scd_x10(accel_units[15:0]);
                mode_d = CODE_W'(POSITION_VELOCITY_COMMAND_CODE);
                drop_d = 1'b0;
              end
            end
            default: begin
              drop_d = 1'b1;
            end
          endcase
        end
        strobe_d = !drop_d;
        if (!drop_d && (code != ORIGIN_COMMAND_CODE)) begin
          mode_valid_d = 1'b1;
        end
      end
      default: begin
        state_d = SCD_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= SCD_IDLE;
      ready_q <= 1'b0;
      id_q <= '0;
      dlc_q <= '0;
      data_q <= '0;
      ext_q <= 1'b0;
      remote_q <= 1'b0;
      strobe_q <= 1'b0;
      drop_q <= 1'b0;
      mode_valid_q <= 1'b0;
      mode_q <= '0;
      duty_q <= '0;
      iq_q <= '0;
      brake_q <= '0;
      vel_q <= '0;
      pos_q <= '0;
      spd_q <= '0;
      acc_q <= '0;
      origin_q <= 1'b0;
      perm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      id_q <= id_d;
      dlc_q <= dlc_d;
      data_q <= data_d;
      ext_q <= ext_d;
      remote_q <= remote_d;
      strobe_q <= strobe_d;
      drop_q <= drop_d;
      mode_valid_q <= mode_valid_d;
      mode_q <= mode_d;
      duty_q <= duty_d;
      iq_q <= iq_d;
      brake_q <= brake_d;
      vel_q <= vel_d;
      pos_q <= pos_d;
      spd_q <= spd_d;
      acc_q <= acc_d;
      origin_q <= origin_d;
      perm_q <= perm_d;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flops
  // ****************************************************************
  assign frame_ready_out = ready_q;
  assign command_strobe_out = strobe_q;
  assign frame_drop_out = drop_q;
  assign mode_valid_out = mode_valid_q;
  assign mode_out = mode_q;
  assign duty_out = duty_q;
  assign quadrature_current_out = iq_q;
  assign brake_current_out = brake_q;
  assign velocity_out = vel_q;
  assign position_out = pos_q;
  assign speed_limit_out = spd_q;
  assign accel_limit_out = acc_q;
  assign origin_set_out = origin_q;
  assign origin_permanent_out = perm_q;

endmodule

// file: design/scd_pkg.sv
package scd_pkg;

  // ****************************************************************
  // Identifier layout
  // ****************************************************************
  localparam int ID_W = 29;
  localparam int MODE_MSB = 28;
  localparam int MODE_LSB = 8;
  localparam int MODE_W = MODE_MSB - MODE_LSB + 1;
  localparam int NODE_MSB = 7;
  localparam int NODE_LSB = 0;
  localparam int NODE_W = NODE_MSB - NODE_LSB + 1;

  // ****************************************************************
  // Payload layout, byte 0 in the top lane
  // ****************************************************************
  localparam int DATA_W = 64;
  localparam int WORD_MSB = 63;
  localparam int WORD_LSB = 32;
  localparam int SPEED_MSB = 31;
  localparam int SPEED_LSB = 16;
  localparam int ACCEL_MSB = 15;
  localparam int ACCEL_LSB = 0;
  localparam int BYTE0_MSB = 63;
  localparam int BYTE0_LSB = 56;
  localparam int DLC_W = 4;
  localparam logic [DLC_W-1:0] DLC_ORIGIN = 4'h1;
  localparam logic [DLC_W-1:0] DLC_WORD = 4'h4;
  localparam logic [DLC_W-1:0] DLC_POS_SPD = 4'h8;

  // ****************************************************************
  // Control mode codes
  // ****************************************************************
  localparam int CODE_W = 3;
  localparam logic [MODE_W-1:0] DUTY_COMMAND_CODE = 21'h000000;
  localparam logic [MODE_W-1:0] CURRENT_COMMAND_CODE = 21'h000001;
  localparam logic [MODE_W-1:0] BRAKE_COMMAND_CODE = 21'h000002;
  localparam logic [MODE_W-1:0] VELOCITY_COMMAND_CODE = 21'h000003;
  localparam logic [MODE_W-1:0] POSITION_COMMAND_CODE = 21'h000004;
  localparam logic [MODE_W-1:0] ORIGIN_COMMAND_CODE = 21'h000005;
  localparam logic [MODE_W-1:0] POSITION_VELOCITY_COMMAND_CODE = 21'h000006;

  // ****************************************************************
  // Set-point ranges and scales
  // ****************************************************************
  localparam logic signed [31:0] DUTY_MAX = 32'sh000186A0;
  localparam logic signed [31:0] DUTY_MIN = -32'sh000186A0;
  localparam logic signed [31:0] CURRENT_MAX = 32'sh0000EA60;
  localparam logic signed [31:0] CURRENT_MIN = -32'sh0000EA60;
  localparam logic signed [31:0] BRAKE_MIN = 32'sh00000000;
  localparam logic signed [31:0] VELOCITY_MAX = 32'sh000186A0;
  localparam logic signed [31:0] VELOCITY_MIN = -32'sh000186A0;
  localparam logic signed [31:0] POSITION_MAX = 32'sh15752A00;
  localparam logic signed [31:0] POSITION_MIN = -32'sh15752A00;
  localparam logic signed [31:0] ACCEL_UNIT_MAX = 32'sh00007FFF;
  localparam logic signed [31:0] LIMIT_SCALE = 32'sh0000000A;
  localparam logic signed [31:0] FULL_SPEED = 32'sh000186A0;
  localparam logic signed [31:0] FULL_ACCEL = 32'sh0004FFF6;
  localparam logic signed [31:0] IMPEDANCE_SPEED = 32'sh00002EE0;
  localparam logic signed [31:0] IMPEDANCE_ACCEL = 32'sh00009C40;
  localparam logic [7:0] ORIGIN_TEMPORARY = 8'h00;
  localparam logic [7:0] ORIGIN_PERMANENT = 8'h01;

  // ****************************************************************
  // Decoder states
  // ****************************************************************
  typedef enum logic [1:0] {
    SCD_IDLE = 2'b01,
    SCD_DECODE = 2'b10
  } scd_state_type;

endpackage

// file: tb/scd_decoder_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder port checker
// ****************************************************************
module scd_decoder_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [scd_pkg::NODE_W-1:0] node_id_in,
  input wire logic frame_valid_in,
  input wire logic frame_extended_in,
  input wire logic frame_remote_in,
  input wire logic [scd_pkg::ID_W-1:0] frame_id_in,
  input wire logic [scd_pkg::DLC_W-1:0] frame_dlc_in,
  input wire logic [scd_pkg::DATA_W-1:0] frame_data_in,
  input wire logic frame_ready_out,
  input wire logic command_strobe_out,
  input wire logic frame_drop_out,
  input wire logic [scd_pkg::CODE_W-1:0] mode_out,
  input wire logic signed [31:0] duty_out,
  input wire logic signed [31:0] brake_current_out,
  input wire logic signed [31:0] velocity_out,
  input wire logic origin_set_out,
  input wire logic origin_permanent_out
);
  import scd_pkg::*;
  logic take;
  logic ok;
  logic [2:0] code;
  assign take = frame_valid_in && frame_ready_out;
  assign code = frame_id_in[10:8];
  // Full mode field must be small, so upper bits are checked too
  assign ok = take && frame_extended_in && !frame_remote_in && frame_id_in[7:0] == node_id_in
    && frame_id_in[28:11] == 18'h00000 && code != 3'h7 && code != 3'h5
    && frame_dlc_in >= (code == 3'h6 ? DLC_POS_SPD : DLC_WORD);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_answer; take |=> ##1 (command_strobe_out ^ frame_drop_out); endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_gap; take |=> !frame_ready_out; endproperty
  a_gap: assert property (p_gap) else $error("ready after take");
  property p_std;
    take && (!frame_extended_in || frame_remote_in) |=> ##1 frame_drop_out;
  endproperty
  a_std: assert property (p_std) else $error("standard frame kept");
  property p_node; take && frame_id_in[7:0] != node_id_in |=> ##1 frame_drop_out; endproperty
  a_node: assert property (p_node) else $error("foreign node kept");
  property p_mode; ok |=> ##1 command_strobe_out && mode_out == $past(code, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");
  property p_word;
    ok && code == 3'h3 && $signed(frame_data_in[63:32]) <= VELOCITY_MAX
      && $signed(frame_data_in[63:32]) >= VELOCITY_MIN
      |=> ##1 velocity_out == $past(frame_data_in[63:32], 2);
  endproperty
  a_word: assert property (p_word) else $error("velocity word wrong");
  property p_origin;
    take && frame_extended_in && !frame_remote_in && frame_id_in == {21'h000005, node_id_in}
      && frame_dlc_in >= DLC_ORIGIN && frame_data_in[63:57] == 7'h00
      |=> ##1 origin_set_out && origin_permanent_out == $past(frame_data_in[56], 2);
  endproperty
  a_origin: assert property (p_origin) else $error("origin wrong");
  property p_brake;
    brake_current_out >= BRAKE_MIN && brake_current_out <= 32'sh0000EA60;
  endproperty
  a_brake: assert property (p_brake) else $error("brake out of range");
  property p_hold; !command_strobe_out |-> $stable(duty_out); endproperty
  a_hold: assert property (p_hold) else $error("duty moved");
  c_accept: cover property (ok ##2 command_strobe_out);
  c_drop: cover property (take ##2 frame_drop_out);
  c_origin: cover property (origin_set_out && origin_permanent_out);
endmodule
bind scd_decoder scd_decoder_chk u_chk (.clk_in, .reset_n_in, .node_id_in, .frame_valid_in,
  .frame_extended_in, .frame_remote_in, .frame_id_in, .frame_dlc_in, .frame_data_in,
  .frame_ready_out, .command_strobe_out, .frame_drop_out, .mode_out, .duty_out,
  .brake_current_out, .velocity_out, .origin_set_out, .origin_permanent_out);

// file: tb/scd_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host frame source
// ****************************************************************
module scd_host (
  input wire logic clk_in,
  input wire logic frame_ready_in,
  output logic frame_valid_out,
  output logic frame_extended_out,
  output logic frame_remote_out,
  output logic [scd_pkg::ID_W-1:0] frame_id_out,
  output logic [scd_pkg::DLC_W-1:0] frame_dlc_out,
  output logic [scd_pkg::DATA_W-1:0] frame_data_out
);
  import scd_pkg::*;
  initial begin
    frame_valid_out = 1'b0;
    {frame_extended_out, frame_remote_out, frame_id_out, frame_dlc_out, frame_data_out} = '0;
  end
  // Frame held until taken or 20 cycles pass; released lines invert so stale values never match
  task automatic send(input logic ext, rem, input logic [28:0] id, input logic [3:0] dlc,
                      input logic [63:0] data, output logic taken);
    int n;
    n = 0;
    @(negedge clk_in);
    frame_valid_out = 1'b1;
    frame_extended_out = ext;
    frame_remote_out = rem;
    frame_id_out = id;
    frame_dlc_out = dlc;
    frame_data_out = data;
    while (frame_ready_in !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    taken = n < 20;
    @(negedge clk_in);
    frame_valid_out = 1'b0;
    {frame_extended_out, frame_remote_out} = ~{ext, rem};
    frame_id_out = ~id;
    frame_dlc_out = ~dlc;
    frame_data_out = ~data;
    @(negedge clk_in);
  endtask
endmodule

// file: tb/servo_can_command_decoder_test.sv
`timescale 1ns/1ps
// ****************************************************************
// Decoder bench
// ****************************************************************
module servo_can_command_decoder_test;
  import scd_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] node_id = 8'h2A;
  logic imp = 1'b0;
  logic fv, fe, fr, rdy, stb, drp, mv, os, op;
  logic [28:0] fid;
  logic [3:0] fdlc;
  logic [63:0] fdat;
  logic [2:0] mode;
  logic signed [31:0] duty, iq, brk, vel, pos, spd, acc;
  int fail_count = 0;
  int n_checks = 0;
  always #2.5 clk_in = ~clk_in;
  scd_host host (.clk_in(clk_in), .frame_ready_in(rdy), .frame_valid_out(fv),
    .frame_extended_out(fe), .frame_remote_out(fr), .frame_id_out(fid),
    .frame_dlc_out(fdlc), .frame_data_out(fdat));
  scd_decoder uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .node_id_in(node_id),
    .impedance_select_in(imp), .frame_valid_in(fv), .frame_extended_in(fe),
    .frame_remote_in(fr), .frame_id_in(fid), .frame_dlc_in(fdlc), .frame_data_in(fdat),
    .frame_ready_out(rdy), .command_strobe_out(stb), .frame_drop_out(drp),
    .mode_valid_out(mv), .mode_out(mode), .duty_out(duty), .quadrature_current_out(iq),
    .brake_current_out(brk), .velocity_out(vel), .position_out(pos),
    .speed_limit_out(spd), .accel_limit_out(acc), .origin_set_out(os),
    .origin_permanent_out(op));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Sends one frame and checks which pulse answers it
  task go(input logic ext, rem, input logic [28:0] id, input logic [3:0] dlc,
          input logic [63:0] data, input logic accept);
    logic t;
    host.send(ext, rem, id, dlc, data, t);
    check("taken", t, 1'b1);
    check("strobe", stb, accept);
    check("drop", drp, !accept);
  endtask
  function automatic logic signed [31:0] pick(input logic [2:0] c);
    case (c)
      3'h0: return duty;
      3'h1: return iq;
      3'h2: return brk;
      3'h3: return vel;
      default: return pos;
    endcase
  endfunction
  task t_modes;
    logic [2:0] c[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    logic [31:0] w[6] = '{32'h0000C350, 32'hFFFF8AD0, 32'h000004D2, 32'hFFFE7960,
                          32'h15752A00, 32'h12345678};
    for (int i = 0; i < 6; i++) begin
      go(1'b1, 1'b0, {18'h0, c[i], node_id}, 4'h8, {w[i], 32'hFFF60064}, 1'b1);
      check("mode", mode, c[i]);
      check("value", pick(c[i]), w[i]);
    end
    check("speed", spd, 32'hFFFFFF9C);
    check("accel", acc, 32'h000003E8);
    check("valid", mv, 1'b1);
    $display("modes done");
  endtask
  task t_drops;
    logic [63:0] d;
    d = {32'h00000055, 32'h0};
    go(1'b0, 1'b0, {21'h3, node_id}, 4'h4, d, 1'b0);
    go(1'b1, 1'b1, {21'h3, node_id}, 4'h4, d, 1'b0);
    go(1'b1, 1'b0, {21'h3, 8'h2B}, 4'h4, d, 1'b0);
    go(1'b1, 1'b0, {21'h7, node_id}, 4'h4, d, 1'b0);
    go(1'b1, 1'b0, {21'h100003, node_id}, 4'h4, d, 1'b0);
    go(1'b1, 1'b0, {21'h3, node_id}, 4'h3, d, 1'b0);
    go(1'b1, 1'b0, {21'h6, node_id}, 4'h7, d, 1'b0);
    go(1'b1, 1'b0, {21'h5, node_id}, 4'h1, {8'h02, 56'h0}, 1'b0);
    check("vel_kept", vel, 32'hFFFE7960);
    $display("drops done");
  endtask
  task t_sat;
    logic [2:0] c[3] = '{3'h1, 3'h2, 3'h0};
    logic [31:0] w[3] = '{32'h00011170, 32'hFFFFFFFB, 32'hFFFCF2C0};
    logic [31:0] e[3] = '{32'h0000EA60, 32'h00000000, 32'hFFFE7960};
    for (int i = 0; i < 3; i++) begin
      go(1'b1, 1'b0, {18'h0, c[i], node_id}, 4'h4, {w[i], 32'h0}, 1'b1);
      check("sat", pick(c[i]), e[i]);
    end
    go(1'b1, 1'b0, {21'h6, node_id}, 4'h8, {32'h0, 32'h7FFFFFFF}, 1'b1);
    check("spd_top", spd, 32'h0004FFF6);
    check("acc_neg", acc, 32'h00000000);
    $display("saturation done");
  endtask
  task t_imp;
    go(1'b1, 1'b0, {21'h4, node_id}, 4'h4, 64'h0, 1'b1);
    check("full_spd", spd, FULL_SPEED);
    check("full_acc", acc, FULL_ACCEL);
    imp = 1'b1;
    go(1'b1, 1'b0, {21'h4, node_id}, 4'h4, 64'h0, 1'b1);
    check("imp_spd", spd, 32'h00002EE0);
    check("imp_acc", acc, 32'h00009C40);
    imp = 1'b0;
    $display("impedance done");
  endtask
  task t_origin;
    for (int b = 1; b >= 0; b--) begin
      go(1'b1, 1'b0, {21'h5, node_id}, 4'h1, {b[7:0], 56'h0}, 1'b1);
      check("org_set", os, 1'b1);
      check("org_perm", op, b[0]);
      check("org_mode", mode, 3'h4);
      @(negedge clk_in);
      check("org_pulse", os, 1'b0);
    end
    $display("origin done");
  endtask
  // Mid-run reset, then an origin alone must not make a mode valid
  task t_reset;
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("rst_ready", rdy, 1'b0);
    check("rst_vel", vel, 32'h0);
    check("rst_valid", mv, 1'b0);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    check("rst_ready_up", rdy, 1'b1);
    go(1'b1, 1'b0, {21'h5, node_id}, 4'h1, 64'h0, 1'b1);
    check("org_no_mode", mode, 3'h0);
    check("org_no_valid", mv, 1'b0);
    $display("reset done");
  endtask
  initial begin
    #25000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(negedge clk_in);
    check("ready_rst", rdy, 1'b0);
    reset_n_in = 1'b1;
    t_modes();
    t_drops();
    t_sat();
    t_imp();
    t_origin();
    t_reset();
    finish_test();
  end
endmodule
